// File: design/fws_pkg.sv
// Purpose: Shared constants for the flash write-status host controller.
// Assumes: 40 MHz system clock; parallel 8-bit asynchronous flash outside.
// Notes:   Register offsets and status fields are used by the controller.
`default_nettype none
package fws_pkg;
  // ==========================================================================
  // Clock and timing.
  // ==========================================================================
  localparam int CLK_HZ         = 40_000_000; // System clock rate.
  localparam int GAP_MAX_US     = 80;         // Longest sector-erase gap.
  // Longest time rounds down to whole cycles.
  localparam int GAP_MAX_CYC    = (GAP_MAX_US * (CLK_HZ / 1_000_000));
  localparam int STROBE_CYC     = 4;          // Cycles in S_STRB; each strobe stays low for 3.
  // ==========================================================================
  // Register offsets of the controller's own register file.
  // ==========================================================================
  localparam logic [3:0] REG_CTRL   = 4'h0;  // Command: start code; any nonzero code starts it.
  localparam logic [3:0] REG_ADDR   = 4'h1;  // Target flash address.
  localparam logic [3:0] REG_DATA   = 4'h2;  // Byte to program.
  localparam logic [3:0] REG_STATUS = 4'h3;  // Controller state and result.
  localparam logic [3:0] REG_LAST   = 4'h4;  // Last byte read from flash.
  // ==========================================================================
  // Command codes in REG_CTRL[2:0].
  // ==========================================================================
  localparam logic [2:0] CMD_WRITE  = 3'h1;  // Raw bus write of DATA to ADDR.
  localparam logic [2:0] CMD_READ   = 3'h2;  // Single read of ADDR.
  localparam logic [2:0] CMD_POLL   = 3'h3;  // Data-polling wait on ADDR.
  localparam logic [2:0] CMD_TOGGLE = 3'h4;  // Toggle-bit wait on ADDR.
  localparam logic [2:0] CMD_WINDOW = 3'h5;  // Read erase-window bit at ADDR.
  // ==========================================================================
  // Status bit positions on the flash data bus.
  // ==========================================================================
  localparam int BIT_POLL   = 7;  // data_poll_bit.
  localparam int BIT_TOGGLE = 6;  // toggle_bit.
  localparam int BIT_LIMIT  = 5;  // time_limit_flag.
  localparam int BIT_WINDOW = 3;  // erase_window_bit.
  localparam int BIT_SECTOR = 2;  // sector_toggle_bit.
  // ==========================================================================
  // Status register fields.
  // ==========================================================================
  localparam int ST_BUSY    = 0;  // Command in progress.
  localparam int ST_DONE    = 1;  // Last command finished well.
  localparam int ST_FAIL    = 2;  // Time-limit flag was seen.
  localparam int ST_SECTOR  = 3;  // Sector toggle bit toggled at ADDR.
  localparam int ST_WINDOW  = 4;  // Erase window was open (bit low).
  localparam int ST_GAPLATE = 5;  // Sector-erase gap limit exceeded.
endpackage : fws_pkg
`default_nettype wire

// File: design/fws_sync.sv
// Purpose: Three-flop synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to CLK_SYS.
// Notes:   Output changes only once the second and third stages agree.
`default_nettype none
module fws_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  // ==========================================================================
  // Synchroniser stages.
  // ==========================================================================
  logic [W-1:0] s1; // First stage, read only by s2.
  logic [W-1:0] s2; // Second stage.
  logic [W-1:0] s3; // Third stage.
  // Shift the pin through three flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Accept a bit only where the last two stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  end
endmodule : fws_sync
`default_nettype wire

// File: design/fws_host.sv
// Purpose: Host-side controller that writes flash commands and polls status.
// Assumes: Software stages raw command writes; the controller times the bus.
// Notes:   Read strobes are full chip-select and output-enable cycles.
`default_nettype none
module fws_host
  import fws_pkg::*;
#(
  parameter int AW        = 20,          // Flash address width.
  parameter int GAP_LIMIT = GAP_MAX_CYC  // Cycles allowed between write commands.
) (
  input  wire logic          CLK_SYS,
  input  wire logic          RST_N,
  input  wire logic [3:0]    REG_ADDR_IN,
  input  wire logic [31:0]   REG_WDATA,
  input  wire logic          REG_WR,
  input  wire logic          REG_RD,
  output var  logic [31:0]   REG_RDATA,
  output var  logic [AW-1:0] FL_ADDR,
  output var  logic [7:0]    FL_DQ_OUT,
  output var  logic          FL_DQ_OE,
  input  wire logic [7:0]    FL_DQ_IN,
  output var  logic          FL_CE_N,
  output var  logic          FL_OE_N,
  output var  logic          FL_WE_N,
  output var  logic          BUSY
);
  // ==========================================================================
  // Elaboration checks.
  // ==========================================================================
  if (AW < 1 || AW > 28) begin : g_aw_chk
    $error("Address width out of range.");
  end
  if (GAP_LIMIT < 1) begin : g_gap_chk
    $error("Gap limit must be at least one cycle.");
  end
  // ==========================================================================
  // State machine, Gray coded from S_IDLE through to S_DONE.
  // ==========================================================================
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,  // Waiting for a command.
    S_STRB  = 3'b001,  // Strobe low.
    S_HOLD  = 3'b011,  // Strobe high, sample or recover.
    S_EVAL  = 3'b010,  // Decide on the next step.
    S_DONE  = 3'b110   // Report and return.
  } fws_state_e;
  fws_state_e state;          // Current state.
  logic [2:0]  cmd;           // Command in progress.
  logic [AW-1:0] addr;        // Target address register.
  logic [7:0]  wdata;         // Byte to write, also expected data.
  logic [7:0]  rd_now;        // Byte from the latest read.
  logic [7:0]  rd_prev;       // Byte from the read before.
  logic        have_prev;     // A previous read exists for comparison.
  logic        reread;        // Polling bit matched; one more read owed.
  logic [7:0]  last;          // Byte shown in REG_LAST.
  logic [2:0]  cnt;           // Strobe width counter.
  logic [4:0]  stat;          // Status flags; the gap flag lives apart.
  logic [31:0] gap_cnt;       // Cycles since the last write command's S_EVAL.
  logic        gap_run;       // Gap counter is running.
  logic        stat_gap_late; // Previous write followed too late.
  logic [7:0]  dq_sync;       // Synchronised data bus.
  logic        is_write;      // Current cycle is a write.
  // Synchronise the data pins into the clock domain.
  fws_sync #(.W(8)) u_sync (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .din   (FL_DQ_IN),
    .dout  (dq_sync)
  );
  assign is_write = (cmd == CMD_WRITE);
  // ==========================================================================
  // Register writes from software.
  // ==========================================================================
  // Load address and data; software stages the write sequences itself.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      addr  <= '0;
      wdata <= 8'h00;
    end else if (REG_WR && state == S_IDLE) begin
      if (REG_ADDR_IN == REG_ADDR) begin
        addr <= REG_WDATA[AW-1:0];
      end
      if (REG_ADDR_IN == REG_DATA) begin
        wdata <= REG_WDATA[7:0];
      end
    end
  end
  // ==========================================================================
  // Sequencer for bus cycles and status evaluation.
  // ==========================================================================
  // Runs one write, one read or a series of status reads.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state     <= S_IDLE;
      cmd       <= 3'h0;
      cnt       <= 3'h0;
      rd_now    <= 8'h00;
      rd_prev   <= 8'h00;
      have_prev <= 1'b0;
      reread    <= 1'b0;
      last      <= 8'h00;
      stat      <= 5'h00;
    end else begin
      case (state)
        S_IDLE: begin
          // A go write to CTRL starts a command; refused while busy.
          if (REG_WR && REG_ADDR_IN == REG_CTRL && REG_WDATA[2:0] != 3'h0) begin
            cmd       <= REG_WDATA[2:0];
            state     <= S_STRB;
            cnt       <= 3'h0;
            have_prev <= 1'b0;
            reread    <= 1'b0;
            stat[ST_BUSY]   <= 1'b1;
            stat[ST_DONE]   <= 1'b0;
            stat[ST_FAIL]   <= 1'b0;
            stat[ST_SECTOR] <= 1'b0;
            stat[ST_WINDOW] <= 1'b0;
          end
        end
        S_STRB: begin
          // Hold the strobe low for its width.
          cnt <= cnt + 3'h1;
          if (cnt == 3'(STROBE_CYC - 1)) begin
            state   <= S_HOLD;
            cnt     <= 3'h0;
          end
        end
        S_HOLD: begin
          // Strobes high: every read is its own chip-select cycle.
          cnt <= cnt + 3'h1;
          // The read byte leaves the synchroniser one cycle after the strobes rise.
          if (cnt == 3'h1) begin
            rd_prev <= rd_now;
            rd_now  <= dq_sync;
          end
          if (cnt == 3'(STROBE_CYC - 1)) begin
            state <= S_EVAL;
          end
        end
        S_EVAL: begin
          last <= rd_now;
          cnt  <= 3'h0;
          case (cmd)
            CMD_WRITE, CMD_READ: begin
              stat[ST_DONE] <= 1'b1;
              state <= S_DONE;
            end
            CMD_WINDOW: begin
              // Low means more sector erases are still accepted.
              stat[ST_WINDOW] <= ~rd_now[BIT_WINDOW];
              stat[ST_DONE]   <= 1'b1;
              state <= S_DONE;
            end
            CMD_POLL: begin
              // Polling bit equal to expected bit 7 means done.
              if (reread) begin
                // Second read gives all eight bits as true data.
                stat[ST_DONE] <= 1'b1;
                state <= S_DONE;
              end else if (rd_now[BIT_POLL] == wdata[BIT_POLL]) begin
                reread <= 1'b1;
                state  <= S_STRB;
              end else if (rd_now[BIT_LIMIT]) begin
                // Time-limit flag with polling bit unmatched: declare failure at once.
                stat[ST_FAIL] <= 1'b1;
                state <= S_DONE;
              end else begin
                state <= S_STRB;
              end
            end
            CMD_TOGGLE: begin
              // Compare two back-to-back reads at one address.
              have_prev <= 1'b1;
              if (have_prev) begin
                stat[ST_SECTOR] <= rd_now[BIT_SECTOR] ^ rd_prev[BIT_SECTOR];
                if (rd_now[BIT_TOGGLE] == rd_prev[BIT_TOGGLE]) begin
                  // Stopped toggling; valid data next, covers suspend.
                  stat[ST_DONE] <= 1'b1;
                  state <= S_DONE;
                end else if (rd_now[BIT_LIMIT]) begin
                  // Flag seen while toggling: fail, sector bit kept.
                  stat[ST_FAIL] <= 1'b1;
                  state <= S_DONE;
                end else begin
                  state <= S_STRB;
                end
              end else begin
                state <= S_STRB;
              end
            end
            default: begin
              state <= S_DONE;
            end
          endcase
        end
        S_DONE: begin
          stat[ST_BUSY] <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
  // ==========================================================================
  // Gap timer between command writes.
  // ==========================================================================
  // Flags a write that follows the previous one too late.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      gap_cnt <= 32'h0;
      gap_run <= 1'b0;
      stat_gap_late <= 1'b0;
    end else begin
      if (state == S_EVAL && is_write) begin
        gap_cnt <= 32'h0;
        gap_run <= 1'b1;
        stat_gap_late <= gap_run && (gap_cnt >= 32'(GAP_LIMIT));
      end else if (gap_run && gap_cnt != 32'hFFFF_FFFF) begin
        gap_cnt <= gap_cnt + 32'h1;
      end
    end
  end
  // ==========================================================================
  // Pin drivers, all from flip-flops.
  // ==========================================================================
  // Strobes low in S_STRB; data driven for the whole write cycle.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FL_CE_N   <= 1'b1;
      FL_OE_N   <= 1'b1;
      FL_WE_N   <= 1'b1;
      FL_DQ_OE  <= 1'b0;
      FL_DQ_OUT <= 8'h00;
      FL_ADDR   <= '0;
      BUSY      <= 1'b0;
    end else begin
      FL_ADDR   <= addr;
      FL_DQ_OUT <= wdata;
      BUSY      <= (state != S_IDLE);
      FL_CE_N   <= !(state == S_STRB && cnt != 3'(STROBE_CYC - 1));
      FL_WE_N   <= !(state == S_STRB && cnt != 3'(STROBE_CYC - 1) && is_write);
      FL_OE_N   <= !(state == S_STRB && cnt != 3'(STROBE_CYC - 1) && !is_write);
      FL_DQ_OE  <= (state == S_STRB || state == S_HOLD) && is_write;
    end
  end
  // ==========================================================================
  // Register read port, data one cycle after the strobe.
  // ==========================================================================
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR_IN)
        REG_CTRL:   REG_RDATA <= {29'h0, cmd};
        REG_ADDR:   REG_RDATA <= 32'(addr);
        REG_DATA:   REG_RDATA <= {24'h0, wdata};
        REG_STATUS: REG_RDATA <= {26'h0, stat_gap_late, stat[4:0]};
        REG_LAST:   REG_RDATA <= {24'h0, last};
        default:    REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end
  // ==========================================================================
  // Assertions.
  // ==========================================================================
  AST_ONE_STROBE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !(!FL_WE_N && !FL_OE_N)) else $error("Write and read strobes overlap.");
  AST_WRITE_DRIVES: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !FL_WE_N |-> FL_DQ_OE) else $error("Write strobe without data drive.");
  AST_READ_RELEASE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !FL_OE_N |-> !FL_DQ_OE) else $error("Read while driving the bus.");
  AST_OE_GAP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(FL_OE_N) |-> FL_OE_N [*3]) else $error("Read cycles not separated.");
  AST_POLL_REREAD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state == S_EVAL && cmd == CMD_POLL && reread) |=> stat[ST_DONE])
    else $error("Poll reread did not complete.");
  AST_TOGGLE_PAIR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state == S_EVAL && cmd == CMD_TOGGLE && !have_prev) |=> state == S_STRB)
    else $error("Toggle check ended after one read.");
  AST_FAIL_STOP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(stat[ST_FAIL]) |-> ##[1:2] state == S_IDLE)
    else $error("Failure did not end the command.");
  AST_BUSY_CMD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (state == S_IDLE && REG_WR && REG_ADDR_IN == REG_CTRL && REG_WDATA[2:0] != 3'h0)
    |=> ##1 BUSY) else $error("Busy not raised for a command.");
  COV_POLL: cover property (@(posedge CLK_SYS) stat[ST_DONE] && cmd == CMD_POLL);
  COV_TOGGLE: cover property (@(posedge CLK_SYS) stat[ST_DONE] && cmd == CMD_TOGGLE);
  COV_FAIL: cover property (@(posedge CLK_SYS) stat[ST_FAIL]);
endmodule : fws_host
`default_nettype wire

// File: verif/fws_flash_model.sv
// Purpose: Behavioural flash device that answers the host controller.
// Assumes: The bench sets op and busy before the arming write strobe.
// Notes:   Deselected data lines show the inverse of the driven value.
`default_nettype none
module fws_flash_model (
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  din,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  op,
  input  wire logic [7:0]  busy,
  input  wire logic [19:0] sec,
  input  wire logic        susp,
  output var  logic [7:0]  dout,
  output var  int          reads
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last = 8'hFF;  // Byte last written.
  logic [7:0] arr  = 8'hFF;  // Array byte given in read mode.
  logic [7:0] n    = 8'h00;  // Status reads still to come.
  logic [1:0] mode = 2'd0;   // 1 program, 2 erase, 3 failed erase.
  logic       tog  = 1'b0;   // Toggle bit state.
  logic       stog = 1'b0;   // Sector toggle bit state.
  int         gap  = 0;      // Reads since the last write closes the window.
  logic [7:0] q;             // Byte shown while selected.
  logic       hit;           // Address lies in the erasing sector.
  wire logic  wr_on;         // Chip select and write strobe both low.
  wire logic  rd_on;         // Chip select and output enable both low.
  // A cycle ends on whichever strobe rises first.
  assign wr_on = !ce_n && !we_n;
  assign rd_on = !ce_n && !oe_n;
  // ==========================================================================
  // Status composition.
  // ==========================================================================
  // Status replaces array data while an operation runs or after a failed erase.
  always_comb begin
    hit = (addr[19:16] == sec[19:16]);
    q   = arr;
    if (n != 8'h00 || mode == 2'd3) begin
      q[6]   = tog;
      q[5]   = (mode == 2'd3);
      q[4]   = 1'b0;
      q[3]   = (mode != 2'd1) && (gap >= 2);
      q[2]   = (mode == 2'd1) ? 1'b1 : (hit & stog);
      q[1:0] = 2'b01;
      q[7]   = (mode == 2'd1) ? ~last[7] : 1'b0;
      if (n == 8'h01 && mode != 2'd3) begin
        q[7] = arr[7];
      end
    end
    // A suspended erase leaves the other sectors readable.
    if (susp && !hit) begin
      q = arr;
    end
  end
  assign dout = rd_on ? q : ~q;
  // A write strobe records the byte and may start an operation.
  // The top sector is protected: status runs, the array stays as it is.
  always @(negedge wr_on) begin
    begin
      last = din;
      gap  = 0;
      if (op != 2'd0) begin
        mode = op;
        n    = busy;
        if (addr[19:16] != 4'hF) begin
          arr = (op == 2'd1) ? din : 8'hFF;
        end
      end
    end
  end
  // Each completed read cycle advances the toggle bit, the sector toggle inside the erasing sector, and the busy count.
  always @(negedge rd_on) begin
    begin
      reads++;
      gap++;
      tog = ~tog;
      if (hit) begin
        stog = ~stog;
      end
      if (n != 8'h00) begin
        n--;
      end
    end
  end
  initial reads = 0;
endmodule : fws_flash_model
`default_nettype wire

// File: verif/fws_host_test.sv
// Purpose: Self-checking bench for the flash write-status host controller.
// Assumes: The flash model stands on the far side of the flash pins.
// Notes:   The gap limit is shortened to 50 cycles.
`default_nettype none
module fws_host_test;
  import fws_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int GAP = 50;  // Shortened gap limit.
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [19:0] fl_addr;
  logic [7:0]  fl_dq_out;
  logic [7:0]  fl_dq_in;
  logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, busy;
  logic [1:0]  op    = 2'd0;   // Operation the next write starts.
  logic [7:0]  nbusy = 8'h00;  // Status reads it lasts.
  logic        susp  = 1'b0;   // Erase suspended in the model.
  int          reads;
  int          r0;
  int          errors = 0;
  int          compares = 0;
  logic [31:0] d;
  always #12.5 clk_sys = ~clk_sys;
  fws_host #(.AW(20), .GAP_LIMIT(GAP)) fws_host_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR_IN(reg_addr_in),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .FL_ADDR(fl_addr), .FL_DQ_OUT(fl_dq_out),
    .FL_DQ_OE(fl_dq_oe), .FL_DQ_IN(fl_dq_in), .FL_CE_N(fl_ce_n),
    .FL_OE_N(fl_oe_n), .FL_WE_N(fl_we_n), .BUSY(busy));
  fws_flash_model fws_flash_model_inst (
    .addr(fl_addr), .din(fl_dq_out), .ce_n(fl_ce_n), .oe_n(fl_oe_n),
    .we_n(fl_we_n), .op(op), .busy(nbusy), .sec(20'h30000), .susp(susp),
    .dout(fl_dq_in), .reads(reads));
  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr_in <= a;
    reg_wdata   <= v;
    reg_wr      <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr_in <= a;
    reg_rd      <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  // Stage a command, wait for it under a bound, then fetch status.
  task automatic run(input logic [2:0] c, input logic [19:0] a, input logic [7:0] dt);
    r0 = reads;
    wr(REG_ADDR, {12'h000, a});
    wr(REG_DATA, {24'h000000, dt});
    wr(REG_CTRL, {29'h0, c});
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge clk_sys);
    chk("busy", {31'h0, busy}, 32'h0);
    rd(REG_STATUS, d);
  endtask : run
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================================
  // Tests.
  // ==========================================================================
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_STATUS, d);
    chk("reset status", d, 32'h0);
    chk("idle strobes", {28'h0, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe}, 32'hE);
    $display("test reset done");
    // Program: inverted polling bit for two reads, then true bit, then data.
    op    <= 2'd1;
    nbusy <= 8'h03;
    run(CMD_WRITE, 20'h12345, 8'h5A);
    op <= 2'd0;
    run(CMD_POLL, 20'h12345, 8'h5A);
    chk("poll result", d[2:0], 32'h2);
    chk("poll reads", reads - r0, 32'h4);
    rd(REG_LAST, d);
    chk("poll last", d[7:0], 32'h5A);
    // Protected sector: status for a short while, stored byte untouched.
    op    <= 2'd1;
    nbusy <= 8'h02;
    run(CMD_WRITE, 20'hF0000, 8'h00);
    op <= 2'd0;
    run(CMD_TOGGLE, 20'hF0000, 8'h00);
    rd(REG_LAST, d);
    chk("protected program", d[7:0], 32'h5A);
    op <= 2'd2;
    run(CMD_WRITE, 20'hF0000, 8'h30);
    op <= 2'd0;
    run(CMD_TOGGLE, 20'hF0000, 8'h00);
    rd(REG_LAST, d);
    chk("protected erase", d[7:0], 32'h5A);
    $display("test program done");
    // Erase: polling bit reads zero until done, toggle stops afterwards.
    op    <= 2'd2;
    nbusy <= 8'h03;
    run(CMD_WRITE, 20'h30000, 8'h30);
    op <= 2'd0;
    run(CMD_POLL, 20'h30000, 8'h80);
    chk("erase poll", d[2:0], 32'h2);
    op    <= 2'd2;
    nbusy <= 8'h05;
    run(CMD_WRITE, 20'h30000, 8'h30);
    op <= 2'd0;
    run(CMD_TOGGLE, 20'h30000, 8'h00);
    chk("erase toggle", d[2:0], 32'h2);
    rd(REG_LAST, d);
    chk("toggle last", d[7:0], 32'hFF);
    $display("test erase done");
    // Window open right after the write, closed after two more reads.
    op    <= 2'd2;
    nbusy <= 8'h14;
    run(CMD_WRITE, 20'h30000, 8'h30);
    op <= 2'd0;
    run(CMD_WINDOW, 20'h30000, 8'h00);
    chk("window open", d[4], 32'h1);
    run(CMD_WINDOW, 20'h30000, 8'h00);
    run(CMD_WINDOW, 20'h30000, 8'h00);
    chk("window shut", d[4], 32'h0);
    susp <= 1'b1;
    run(CMD_READ, 20'h10000, 8'h00);
    susp <= 1'b0;
    rd(REG_LAST, d);
    chk("suspended other sector", d[7:0], 32'hFF);
    repeat (GAP + 10) @(posedge clk_sys);
    run(CMD_WRITE, 20'h40000, 8'h30);
    chk("gap late", d[5], 32'h1);
    run(CMD_WRITE, 20'h40000, 8'h30);
    chk("gap in time", d[5], 32'h0);
    $display("test window done");
    // Unmapped write must not start anything.
    wr(4'hF, 32'hFFFFFFFF);
    repeat (4) @(posedge clk_sys);
    chk("unmapped", {31'h0, busy}, 32'h0);
    // Failed erase: time-limit flag, sector bit toggles only at the failed sector.
    op <= 2'd3;
    run(CMD_WRITE, 20'h30000, 8'h30);
    op <= 2'd0;
    run(CMD_TOGGLE, 20'h30000, 8'h00);
    chk("fail flag", d[2], 32'h1);
    chk("fail sector", d[3], 32'h1);
    run(CMD_TOGGLE, 20'h10000, 8'h00);
    chk("other sector", d[3], 32'h0);
    $display("test failure done");
    end_of_test();
  end
  // Watchdog: the tests need well under forty thousand cycles.
  initial begin
    #(40_000 * 25);
    errors++;
    end_of_test();
  end
endmodule : fws_host_test
`default_nettype wire
